// file: pkg/qpot_pkg.sv
/*
  constants for the quad potentiometer two-wire slave: command opcodes,
  field positions, reset values and write-cycle timing.
  assumes a 100 MHz system clock sampling the two-wire bus pins.
*/
package qpot_pkg;

  localparam int CLOCK_MHZ = 100;
  // typical nonvolatile write cycle, milliseconds
  localparam int NV_WRITE_TIME_MS = 5;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_MS * 1000 * CLOCK_MHZ;
  localparam int NV_CNT_W = 20;

  // device type identifier, value is arbitrary
  localparam logic [3:0] DEVICE_TYPE_ID = 4'ha;

  localparam int POT_COUNT = 4;
  localparam int REGS_PER_POT = 4;
  localparam int WIPER_W = 8;
  localparam int TAP_COUNT = 256;

  // command byte fields
  localparam int CMD_OP_MSB = 7;
  localparam int CMD_OP_LSB = 4;
  localparam int CMD_REG_MSB = 3;
  localparam int CMD_REG_LSB = 2;
  localparam int CMD_POT_MSB = 1;
  localparam int CMD_POT_LSB = 0;

  // slave address fields
  localparam int ADDR_TYPE_MSB = 7;
  localparam int ADDR_TYPE_LSB = 4;
  localparam int ADDR_DEV_MSB = 3;
  localparam int ADDR_DEV_LSB = 0;

  localparam logic [3:0] OP_RD_WCR = 4'h9;
  localparam logic [3:0] OP_WR_WCR = 4'ha;
  localparam logic [3:0] OP_RD_DR = 4'hb;
  localparam logic [3:0] OP_WR_DR = 4'hc;
  localparam logic [3:0] OP_XFR_DR_WCR = 4'hd;
  localparam logic [3:0] OP_XFR_WCR_DR = 4'he;
  localparam logic [3:0] OP_GXFR_DR_WCR = 4'h1;
  localparam logic [3:0] OP_GXFR_WCR_DR = 4'h8;

  localparam logic [7:0] DATA_REG_RESET = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_CMD = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;

  typedef enum logic [2:0] {
    QPOT_IDLE,
    QPOT_RX,
    QPOT_ACK,
    QPOT_TX,
    QPOT_MACK,
    QPOT_IGNORE
  } qpot_state_t;

endpackage

// file: rtl/qpot_tap_decoder.sv
/*
  one-of-256 tap decoder for a single potentiometer wiper.
  assumes the wiper position comes from logic on the same clock.
*/
`timescale 1ns/1ps
module qpot_tap_decoder
  import qpot_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIPER_W-1:0] wiper,
  output logic [TAP_COUNT-1:0] tap
);

  // exactly one switch closed
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tap <= TAP_COUNT'(1);
    end
    else
    begin
      tap <= TAP_COUNT'(1) << wiper;
    end
  end

endmodule

// file: rtl/qpot_two_wire_slave.sv
/*
  two-wire serial slave and register set of a quad digital potentiometer.
  assumes scl and sda come asynchronously from a bus master, sda is an
  open-drain wire with external pull-up, and rst models power-up.
*/
`timescale 1ns/1ps
module qpot_two_wire_slave
  import qpot_pkg::*;
#(
  parameter int NV_WRITE_CYCLES_P = NV_WRITE_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] address_strap_inputs,
  input wire logic write_protect_n,
  output logic nv_write_busy,
  output logic [POT_COUNT-1:0][TAP_COUNT-1:0] tap_output
);

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] wp_sync;
  logic [3:0] strap_meta;
  logic [3:0] strap_sync;
  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  qpot_state_t state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] command;
  logic [WIPER_W-1:0] wiper_position_reg [POT_COUNT];
  logic [7:0] data_reg [POT_COUNT*REGS_PER_POT];
  logic [NV_CNT_W-1:0] nv_cnt;
  logic nv_pend;
  logic nv_from_wiper;
  logic nv_global;
  logic [7:0] nv_data;
  logic [3:0] op;
  logic [1:0] data_reg_select;
  logic [1:0] pot_select;
  logic ack_end;
  logic byte_done;
  logic addr_match;
  logic op_valid;
  logic op_read;
  logic op_three;
  logic [7:0] read_value;

  // two-stage synchronisers, then edge history
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      wp_sync <= 2'h3;
      strap_meta <= 4'h0;
      strap_sync <= 4'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl};
      sda_sync <= {sda_sync[0], sda_in};
      wp_sync <= {wp_sync[0], write_protect_n};
      strap_meta <= address_strap_inputs;
      strap_sync <= strap_meta;
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  always_comb
  begin
    scl_rise = scl_sync[1] & ~scl_prev;
    scl_fall = ~scl_sync[1] & scl_prev;
    // sda edge while scl high is a bus condition, not data
    start_seen = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
    stop_seen = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
  end

  // command fields
  always_comb
  begin
    op = command[CMD_OP_MSB:CMD_OP_LSB];
    data_reg_select = command[CMD_REG_MSB:CMD_REG_LSB];
    pot_select = command[CMD_POT_MSB:CMD_POT_LSB];
  end

  always_comb
  begin
    // type and strap compare; busy withholds the ack
    addr_match = (shift[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == DEVICE_TYPE_ID)
                 && (shift[ADDR_DEV_MSB:ADDR_DEV_LSB] == strap_sync)
                 && !nv_write_busy;
    case (shift[CMD_OP_MSB:CMD_OP_LSB])
      OP_RD_WCR, OP_WR_WCR, OP_RD_DR, OP_WR_DR, OP_XFR_DR_WCR, OP_XFR_WCR_DR,
      OP_GXFR_DR_WCR, OP_GXFR_WCR_DR: op_valid = 1'b1;
      default: op_valid = 1'b0;
    endcase
    op_read = (op == OP_RD_WCR) || (op == OP_RD_DR);
    // host writes need a data byte
    op_three = (op == OP_WR_WCR) || (op == OP_WR_DR);
    byte_done = (state == QPOT_RX) && scl_fall && (bit_cnt == BITS_PER_BYTE);
    ack_end = (state == QPOT_ACK) && scl_fall;
    if (op == OP_RD_WCR)
    begin
      read_value = wiper_position_reg[pot_select];
    end
    else
    begin
      read_value = data_reg[{pot_select, data_reg_select}];
    end
  end

  // serial state machine
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= QPOT_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      command <= 8'h00;
      sda_oe <= 1'b0;
    end
    else if (stop_seen)
    begin
      state <= QPOT_IDLE;
      sda_oe <= 1'b0;
    end
    else if (start_seen)
    begin
      state <= QPOT_RX;
      bit_cnt <= 4'h0;
      byte_idx <= BYTE_ADDR;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state)
        QPOT_RX:
        begin
          if (scl_rise && bit_cnt != BITS_PER_BYTE)
          begin
            shift <= {shift[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (byte_done)
          begin
            if (byte_idx == BYTE_ADDR)
            begin
              // mismatch stays released until next start
              state <= addr_match ? QPOT_ACK : QPOT_IGNORE;
              sda_oe <= addr_match;
            end
            else if (byte_idx == BYTE_CMD)
            begin
              command <= shift;
              state <= op_valid ? QPOT_ACK : QPOT_IGNORE;
              sda_oe <= op_valid;
            end
            else
            begin
              state <= QPOT_ACK;
              sda_oe <= 1'b1;
            end
          end
        end
        QPOT_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            byte_idx <= byte_idx + 2'h1;
            sda_oe <= 1'b0;
            if (byte_idx == BYTE_ADDR || (byte_idx == BYTE_CMD && op_three))
            begin
              state <= QPOT_RX;
            end
            else if (byte_idx == BYTE_CMD && op_read)
            begin
              state <= QPOT_TX;
              shift <= read_value;
              sda_oe <= ~read_value[7];
            end
            else
            begin
              state <= QPOT_IGNORE;
            end
          end
        end
        QPOT_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == BIT_LAST)
            begin
              state <= QPOT_MACK;
              sda_oe <= 1'b0;
            end
            else
            begin
              bit_cnt <= bit_cnt + 4'h1;
              shift <= {shift[6:0], 1'b0};
              sda_oe <= ~shift[6];
            end
          end
        end
        QPOT_MACK:
        begin
          if (scl_fall)
          begin
            state <= QPOT_IGNORE;
          end
        end
        QPOT_IDLE, QPOT_IGNORE:
        begin
          sda_oe <= 1'b0;
        end
        default:
        begin
          state <= QPOT_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;

  // pending nonvolatile write, latched on the final ack
  always_ff @(posedge clock)
  begin
    if (rst || start_seen || stop_seen)
    begin
      nv_pend <= 1'b0;
      nv_from_wiper <= 1'b0;
      nv_global <= 1'b0;
      nv_data <= 8'h00;
    end
    else if (ack_end && byte_idx == BYTE_DATA && op == OP_WR_DR)
    begin
      nv_pend <= 1'b1;
      nv_from_wiper <= 1'b0;
      nv_global <= 1'b0;
      nv_data <= shift;
    end
    else if (ack_end && byte_idx == BYTE_CMD
             && (op == OP_XFR_WCR_DR || op == OP_GXFR_WCR_DR))
    begin
      nv_pend <= 1'b1;
      nv_from_wiper <= 1'b1;
      nv_global <= (op == OP_GXFR_WCR_DR);
    end
  end

  // data registers written at stop unless protected
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < POT_COUNT * REGS_PER_POT; i++)
      begin
        data_reg[i] <= DATA_REG_RESET;
      end
    end
    else if (stop_seen && nv_pend && wp_sync[1])
    begin
      for (int p = 0; p < POT_COUNT; p++)
      begin
        if (nv_global || p == int'(pot_select))
        begin
          data_reg[{2'(p), data_reg_select}] <=
            nv_from_wiper ? wiper_position_reg[p] : nv_data;
        end
      end
    end
  end

  // busy timer, inputs disabled meanwhile
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      nv_cnt <= '0;
    end
    else if (stop_seen && nv_pend && wp_sync[1])
    begin
      nv_cnt <= NV_CNT_W'(NV_WRITE_CYCLES_P);
    end
    else if (nv_cnt != '0)
    begin
      nv_cnt <= nv_cnt - NV_CNT_W'(1);
    end
  end

  assign nv_write_busy = (nv_cnt != '0);

  // wiper registers: host load, data register copy, reset to DATA_REG_RESET
  always_ff @(posedge clock)
  begin
    for (int p = 0; p < POT_COUNT; p++)
    begin
      if (rst)
      begin
        wiper_position_reg[p] <= DATA_REG_RESET;
      end
      else if (ack_end && byte_idx == BYTE_DATA && op == OP_WR_WCR
               && p == int'(pot_select))
      begin
        wiper_position_reg[p] <= shift;
      end
      else if (ack_end && byte_idx == BYTE_CMD
               && ((op == OP_XFR_DR_WCR && p == int'(pot_select))
               || op == OP_GXFR_DR_WCR))
      begin
        wiper_position_reg[p] <= data_reg[{2'(p), data_reg_select}];
      end
    end
  end

  // one decoder per channel
  generate
    for (genvar g = 0; g < POT_COUNT; g++)
    begin : g_tap
      qpot_tap_decoder u_dec (
        .clock(clock),
        .rst(rst),
        .wiper(wiper_position_reg[g]),
        .tap(tap_output[g])
      );
    end
  endgenerate

endmodule

// file: tb/qpot_two_wire_slave_assertions.sv
/* port checker for the two-wire slave.
   assumes a bind from the bench top. */
`timescale 1ns/1ps
module qpot_two_wire_slave_assertions
  import qpot_pkg::*;
#(
  parameter int NV_WRITE_CYCLES_P = 50
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [3:0] address_strap_inputs,
  input wire logic write_protect_n,
  input wire logic nv_write_busy,
  input wire logic [POT_COUNT-1:0][TAP_COUNT-1:0] tap_output
);
  logic scl_d;
  logic sda_d;
  logic live;
  int bcnt;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  always_ff @(posedge clock)
  begin
    scl_d <= scl;
    sda_d <= sda_in;
  end
  // set by start, cleared by stop
  always_ff @(posedge clock)
  begin
    if (rst)
      live <= 1'b0;
    else if (scl && scl_d && sda_d != sda_in)
      live <= !sda_in;
  end
  always_ff @(posedge clock)
  begin
    if (rst || !nv_write_busy)
      bcnt <= 0;
    else
      bcnt <= bcnt + 1;
  end
  a_drain_only: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("sda_oe moved with scl high");
  a_oe_after_start: assert property (sda_oe |-> live)
    else $error("sda pulled outside a transfer");
  a_tap_onehot: assert property ($onehot(tap_output[0]) && $onehot(tap_output[1])
    && $onehot(tap_output[2]) && $onehot(tap_output[3]))
    else $error("tap not one-hot");
  a_busy_len: assert property ($fell(nv_write_busy) |-> bcnt == NV_WRITE_CYCLES_P)
    else $error("busy length wrong");
  a_busy_quiet: assert property (nv_write_busy |-> !sda_oe)
    else $error("answer while busy");
  a_busy_after_stop: assert property ($rose(nv_write_busy) |-> scl && sda_in && !live)
    else $error("busy not after stop");
  a_wp_blocks: assert property ($rose(nv_write_busy) |-> $past(write_protect_n, 8))
    else $error("write while protected");
  a_busy_freeze: assert property (nv_write_busy && $past(nv_write_busy) |-> $stable(tap_output))
    else $error("tap moved while busy");
endmodule

// file: tb/qpot_bus_master.sv
/* bus master model driving scl and pulling sda.
   assumes sda resolved with a pull-up in the bench. */
`timescale 1ns/1ps
module qpot_bus_master
(
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  logic s;
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one bit slot of 8 clocks
  task automatic slot(input logic b, output logic v);
    sda_oe = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    v = sda;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic start;
    sda_oe = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop;
    sda_oe = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_oe = 1'b0;
    tick(4);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
      slot(b[i], s);
    slot(1'b1, s);
    ack = !s;
  endtask
  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      slot(1'b1, s);
      b[i] = s;
    end
    slot(1'b1, s);
  endtask
endmodule

// file: tb/qpot_two_wire_slave_bench.sv
/* self-checking bench for the two-wire slave.
   assumes qpot_pkg and the bus master model. */
`timescale 1ns/1ps
module qpot_two_wire_slave_bench;
  import qpot_pkg::*;
  localparam int NV_P = 200;
  localparam int LIMIT = 20000;
  localparam logic [3:0] STRAP = 4'h6;
  localparam logic [7:0] ADDR = {DEVICE_TYPE_ID, STRAP};
  // command, data, pot, wiper after
  localparam logic [31:0] ROWS [9] = '{
    32'ha0ff00ff, 32'ha1010101, 32'ha2800280, 32'ha37e037e, 32'hc93c0101,
    32'hd900013c, 32'he00000ff, 32'h14000200, 32'hd00000ff
  };
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic write_protect_n = 1'b1;
  logic [3:0] strap = STRAP;
  logic scl;
  logic m_oe;
  logic sda_oe;
  logic busy;
  logic ack;
  logic [7:0] rd;
  logic [POT_COUNT-1:0][TAP_COUNT-1:0] tap;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  wire sda = !(sda_oe || m_oe);
  qpot_two_wire_slave #(.NV_WRITE_CYCLES_P(NV_P)) dut (
    .clock(clock),
    .rst(rst),
    .scl(scl),
    .sda_in(sda),
    .sda_out(),
    .sda_oe(sda_oe),
    .address_strap_inputs(strap),
    .write_protect_n(write_protect_n),
    .nv_write_busy(busy),
    .tap_output(tap)
  );
  qpot_bus_master m (
    .clock(clock),
    .sda(sda),
    .scl(scl),
    .sda_oe(m_oe)
  );
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_tap(input logic [7:0] p, input logic [7:0] e);
    logic [TAP_COUNT-1:0] x;
    x = '0;
    x[e] = 1'b1;
    compares++;
    if (tap[p[1:0]] !== x)
    begin
      miscompares++;
      $display("[ERR] tap %0d exp %h got %h", p, x, tap[p[1:0]]);
    end
  endtask
  task automatic xact(input logic [7:0] c, input logic [7:0] d, input bit hold);
    m.start();
    m.put_byte(ADDR, ack);
    chk_val("addr ack", 8'h01, 8'(ack));
    m.put_byte(c, ack);
    chk_val("cmd ack", 8'h01, 8'(ack));
    if (c[7:4] inside {OP_WR_WCR, OP_WR_DR})
    begin
      m.put_byte(d, ack);
      chk_val("data ack", 8'h01, 8'(ack));
    end
    m.stop();
    repeat (8) @(negedge clock);
    while (hold && busy !== 1'b0)
      @(negedge clock);
  endtask
  task automatic rd_reg(input logic [7:0] c, input logic [7:0] e);
    m.start();
    m.put_byte(ADDR, ack);
    m.put_byte(c, ack);
    m.get_byte(rd);
    m.stop();
    chk_val("read", e, rd);
  endtask
  initial
  begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    for (int p = 0; p < POT_COUNT; p++)
      chk_tap(8'(p), 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      xact(ROWS[i][31:24], ROWS[i][23:16], 1'b1);
      chk_tap(ROWS[i][15:8], ROWS[i][7:0]);
    end
    rd_reg(8'h90, 8'hff);
    rd_reg(8'hb9, 8'h3c);
    xact(8'h84, 8'h00, 1'b1);
    rd_reg(8'hb4, 8'hff);
    m.start();
    m.put_byte(ADDR, ack);
    m.put_byte(8'h20, ack);
    chk_val("bad op ack", 8'h00, 8'(ack));
    m.stop();
    write_protect_n = 1'b0;
    xact(8'hcf, 8'h55, 1'b0);
    chk_val("busy", 8'h00, 8'(busy));
    write_protect_n = 1'b1;
    xact(8'hdf, 8'h00, 1'b1);
    chk_tap(8'h03, 8'h00);
    rd_reg(8'hbf, 8'h00);
    xact(8'hc0, 8'h12, 1'b0);
    chk_val("busy", 8'h01, 8'(busy));
    m.start();
    m.put_byte(ADDR, ack);
    m.stop();
    chk_val("poll ack", 8'h00, 8'(ack));
    while (busy !== 1'b0)
      @(negedge clock);
    xact(8'hd0, 8'h00, 1'b1);
    chk_tap(8'h00, 8'h12);
    m.start();
    m.put_byte({~DEVICE_TYPE_ID, STRAP}, ack);
    chk_val("type ack", 8'h00, 8'(ack));
    m.put_byte(8'ha0, ack);
    chk_val("ignored ack", 8'h00, 8'(ack));
    m.stop();
    m.start();
    m.put_byte({DEVICE_TYPE_ID, ~STRAP}, ack);
    chk_val("strap ack", 8'h00, 8'(ack));
    m.start();
    m.put_byte(ADDR, ack);
    m.put_byte(8'ha2, ack);
    m.stop();
    chk_tap(8'h02, 8'h00);
    strap = ~STRAP;
    m.start();
    m.put_byte(ADDR, ack);
    chk_val("strap pin ack", 8'h00, 8'(ack));
    m.stop();
    strap = STRAP;
    rst = 1'b1;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    chk_tap(8'h00, 8'h00);
    wrap_up();
  end
endmodule
bind qpot_two_wire_slave qpot_two_wire_slave_assertions #(
  .NV_WRITE_CYCLES_P(NV_WRITE_CYCLES_P)
) chk (
  .clock(clock),
  .rst(rst),
  .scl(scl),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .address_strap_inputs(address_strap_inputs),
  .write_protect_n(write_protect_n),
  .nv_write_busy(nv_write_busy),
  .tap_output(tap_output)
);
